// ==== hpb_host_port.sv ====
// Host register window, data port FIFOs, byte order and buffer sequencing
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RL1] Expansion mode samples data line zero at strap
// [RL2] Straps pick expansion, card or general bus
// [RL3] Buffer size bit picks 8K or 32K
// [RL4] Bit rate enable divides the crystal clock
// [RL5] Swap bit low: low byte goes first
// [RL6] Swapping only in word bus configuration
// [RL7] Swap only data port words, both directions
// [RL8] Four sets of eight, byte or word
// [RL9] Link control set always at 00-07
// [RL10] Bank field maps one set at 08-0F
// [RL11] Bank code two puts data port at 08
// [RL12] DMA grant forces data port selection
// [RL13] Separate FIFOs, pointers advanced by device
// [RL14] Word config: data port is word-wide only
// [RL15] Host keeps port bank selected normally
// [RL16] Transmit chains packets from one start
// [RL17] Host writes length word then frame bytes
// [RL18] Only low four address bits select registers
module hpb_host_port #(
	parameter int FIFO_DEPTH_LOG2 = 2
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic strap_first,
	input wire logic strap_second,
	input wire logic strap_third,
	input wire logic buffer_data_line_zero,
	input wire logic word_mode,
	input wire logic dma_grant_in,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic host_byte,
	input wire logic [7:0] host_addr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	output logic host_ready,
	output logic [1:0] bus_mode,
	output logic [14:0] sram_addr,
	output logic [7:0] sram_wdata,
	input wire logic [7:0] sram_rdata,
	output logic sram_we_n,
	output logic sram_oe_n,
	output logic bit_tick,
	output logic [2:0] tx_pkt_count
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_WR_HI, ST_RD_LO, ST_RD_HI} st_type;

	localparam int DIV_W = $clog2(hpb_pkg::BIT_DIV);

	typedef struct packed {
		logic [3:0] sy1;
		logic [3:0] sy2;
		logic strap_done;
		logic [1:0] mode;
		logic [63:0] link;
		logic [63:0] station;
		logic [63:0] hash;
		logic [47:0] port_misc;
		st_type st;
		logic [14:0] tx_ptr;
		logic [14:0] rx_ptr;
		logic [15:0] rx_word;
		logic rx_word_ok;
		logic [7:0] wr_hi_byte;
		logic [15:0] rdata;
		logic ready;
		logic [14:0] sram_addr;
		logic [7:0] sram_wdata;
		logic we_n;
		logic oe_n;
		logic [DIV_W-1:0] div;
		logic tick;
		logic [2:0] tx_pkts;
	} hpb_state_type;

	hpb_state_type q, d;

	logic tx_in_ready, tx_out_valid, tx_pop;
	logic [15:0] tx_in_data, tx_out_data;
	logic rx_in_valid, rx_in_ready, rx_out_valid, rx_pop;
	logic [15:0] rx_out_data;
	logic port_sel;
	logic [3:0] reg_idx;
	logic swap_on;
	logic [14:0] addr_mask;
	logic [1:0] bank;
	logic port_rd, port_wr;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign reg_idx = host_addr[3:0]; // RL18
	assign bank = q.link[hpb_pkg::LINK_CONFIG_REG_SEVEN*8+hpb_pkg::BANK_LO_POS
		+: 2];
	assign port_sel = dma_grant_in || // RL12
		(reg_idx[3] && bank == hpb_pkg::HPB_BANK_PORT &&
		reg_idx[2:1] == 2'h0); // RL11
	// Swap only on word bus, only through the data port
	assign swap_on = word_mode && q.link[hpb_pkg::LINK_CONFIG_REG_SEVEN*8 +
		hpb_pkg::SWAP_BIT_POS]; // RL6 RL7
	// Masking lets the pointer wrap inside the fitted SRAM
	assign addr_mask = q.link[hpb_pkg::LINK_CONFIG_REG_SIX*8 +
		hpb_pkg::BUF_SIZE_BIT_POS] ? 15'h7fff : 15'h1fff; // RL3
	// Word config takes only word accesses at the port
	assign port_wr = host_wr && port_sel && !(word_mode && host_byte); // RL14
	assign port_rd = host_rd && port_sel && !(word_mode && host_byte); // RL14
	// Swap on the way in: stored low byte leaves first
	assign tx_in_data = swap_on ? {host_wdata[7:0], host_wdata[15:8]} :
		(word_mode ? host_wdata : {8'h00, host_wdata[7:0]}); // RL5

	// Transmit FIFO: host words toward buffer memory
	hpb_fifo #(.WIDTH(16), .DEPTH_LOG2(FIFO_DEPTH_LOG2)) u_tx_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(port_wr),
		.in_ready(tx_in_ready),
		.in_data(tx_in_data),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_out_data)
	); // RL13

	// Receive FIFO: buffer memory words toward host
	hpb_fifo #(.WIDTH(16), .DEPTH_LOG2(FIFO_DEPTH_LOG2)) u_rx_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(rx_in_valid),
		.in_ready(rx_in_ready),
		.in_data(q.rx_word),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_out_data)
	); // RL13

	assign rx_in_valid = q.rx_word_ok;
	assign rx_pop = port_rd && rx_out_valid;
	assign tx_pop = (q.st == ST_IDLE) && tx_out_valid;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.sy1 = {buffer_data_line_zero, strap_third, strap_second,
			strap_first};
		d.sy2 = q.sy1;
		d.ready = 1'b0;
		d.we_n = 1'b1;
		d.oe_n = 1'b1;
		d.tick = 1'b0;
		if (q.rx_word_ok && rx_in_ready) begin
			d.rx_word_ok = 1'b0;
		end
		// Straps caught once, after the synchroniser settles
		if (!q.strap_done) begin
			d.strap_done = 1'b1;
			if (q.sy2[0]) begin // RL2
				d.mode = q.sy2[3] ? hpb_pkg::HPB_MODE_EXP_JUMPERLESS :
					hpb_pkg::HPB_MODE_EXP_JUMPER; // RL1
			end else if (q.sy2[1]) begin
				d.mode = hpb_pkg::HPB_MODE_CARD;
			end else begin
				d.mode = hpb_pkg::HPB_MODE_GENERAL;
			end
		end
		// Bit rate enable from the crystal clock
		if (q.div == DIV_W'(hpb_pkg::BIT_DIV - 1)) begin
			d.div = '0;
			d.tick = 1'b1; // RL4
		end else begin
			d.div = q.div + 1'b1;
		end
		// Register writes, byte or word
		if (host_wr && !port_sel) begin // RL8
			if (!reg_idx[3]) begin // RL9
				d.link[reg_idx[2:0]*8 +: 8] = host_wdata[7:0];
				if (!host_byte && reg_idx[2:0] != 3'h7) begin
					d.link[(reg_idx[2:0]+3'h1)*8 +: 8] = host_wdata[15:8];
				end
			end else begin // RL10
				unique case (bank)
					hpb_pkg::HPB_BANK_STATION:
						d.station[reg_idx[2:0]*8 +: 8] = host_wdata[7:0];
					hpb_pkg::HPB_BANK_HASH:
						d.hash[reg_idx[2:0]*8 +: 8] = host_wdata[7:0];
					hpb_pkg::HPB_BANK_PORT: begin
						if (reg_idx[2:0] >= 3'h2) begin
							d.port_misc[(reg_idx[2:0]-3'h2)*8 +: 8] =
								host_wdata[7:0];
						end
					end
					// Spare bank holds nothing
					hpb_pkg::HPB_BANK_SPARE: begin
					end
				endcase
			end
			d.ready = 1'b1;
		end
		// Transmit start: count chained packets queued
		if (host_wr && !port_sel && reg_idx == 4'ha &&
			bank == hpb_pkg::HPB_BANK_PORT && host_wdata[7]) begin
			d.tx_pkts = q.tx_pkts + 3'(host_wdata[2:0]); // RL16
		end else if (q.tx_pkts != 3'h0 && q.tick && q.st == ST_IDLE &&
			!tx_out_valid) begin
			d.tx_pkts = q.tx_pkts - 3'h1;
		end
		// Register reads; other registers never swapped
		if (host_rd) begin
			d.ready = 1'b1;
			if (port_sel) begin
				// Refused byte read in word mode gets no answer
				d.ready = port_rd; // RL14
				if (port_rd) begin
					d.rdata = rx_out_data; // RL7
				end
			end else if (!reg_idx[3]) begin
				// Word read of the last link register has no upper byte
				d.rdata[7:0] = q.link[reg_idx[2:0]*8 +: 8];
				d.rdata[15:8] = (reg_idx[2:0] == 3'h7) ? 8'h00 :
					q.link[(reg_idx[2:0]+3'h1)*8 +: 8];
			end else if (bank == hpb_pkg::HPB_BANK_STATION) begin
				d.rdata = {8'h00, q.station[reg_idx[2:0]*8 +: 8]};
			end else if (bank == hpb_pkg::HPB_BANK_HASH) begin
				d.rdata = {8'h00, q.hash[reg_idx[2:0]*8 +: 8]};
			end else if (bank == hpb_pkg::HPB_BANK_PORT) begin
				d.rdata = {8'h00,
					q.port_misc[(reg_idx[2:0]-3'h2)*8 +: 8]};
			end else begin
				d.rdata = 16'h0000;
			end
		end
		if (port_wr) begin
			d.ready = tx_in_ready;
		end
		// Buffer sequencer; writes win over prefetch reads
		unique case (q.st)
			ST_IDLE: begin
				if (tx_out_valid) begin
					d.sram_addr = q.tx_ptr & addr_mask;
					d.sram_wdata = tx_out_data[7:0];
					d.wr_hi_byte = tx_out_data[15:8];
					d.we_n = 1'b0;
					d.tx_ptr = (q.tx_ptr + 15'h1) & addr_mask; // RL13
					d.st = word_mode ? ST_WR_HI : ST_IDLE;
				end else if (!q.rx_word_ok && rx_in_ready) begin
					d.sram_addr = q.rx_ptr & addr_mask;
					d.oe_n = 1'b0;
					d.st = ST_RD_LO;
				end
			end
			ST_WR_HI: begin
				d.sram_addr = q.tx_ptr & addr_mask;
				d.sram_wdata = q.wr_hi_byte;
				d.we_n = 1'b0;
				d.tx_ptr = (q.tx_ptr + 15'h1) & addr_mask;
				d.st = ST_IDLE;
			end
			ST_RD_LO: begin
				d.rx_word = {8'h00, sram_rdata};
				d.rx_ptr = (q.rx_ptr + 15'h1) & addr_mask;
				if (word_mode) begin
					d.sram_addr = (q.rx_ptr + 15'h1) & addr_mask;
					d.oe_n = 1'b0;
					d.st = ST_RD_HI;
				end else begin
					d.rx_word_ok = 1'b1;
					d.st = ST_IDLE;
				end
			end
			ST_RD_HI: begin
				// First byte from memory lands low unless swapped
				d.rx_word = swap_on ? {q.rx_word[7:0], sram_rdata} :
					{sram_rdata, q.rx_word[7:0]}; // RL5
				d.rx_ptr = (q.rx_ptr + 15'h1) & addr_mask;
				d.rx_word_ok = 1'b1;
				d.st = ST_IDLE;
			end
		endcase
		// Sync reset; strap synchroniser keeps running through it
		if (rst) begin
			d = '0;
			d.sy1 = {buffer_data_line_zero, strap_third, strap_second,
				strap_first};
			d.sy2 = q.sy1;
			d.we_n = 1'b1; // Memory strobes idle while held in reset
			d.oe_n = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		q <= d;
	end

	assign host_rdata = q.rdata;
	assign host_ready = q.ready;
	assign bus_mode = q.mode;
	assign sram_addr = q.sram_addr;
	assign sram_wdata = q.sram_wdata;
	assign sram_we_n = q.we_n;
	assign sram_oe_n = q.oe_n;
	assign bit_tick = q.tick;
	assign tx_pkt_count = q.tx_pkts;
endmodule
`default_nettype wire

// ==== hpb_pkg.sv ====
// Shared constants and carrier types of the host port bank block
package hpb_pkg;

	// ------------------------------------------------------------
	// Register window
	// ------------------------------------------------------------
	localparam logic [3:0] LINK_SET_LAST = 4'h7;
	localparam logic [3:0] buffer_data_port = 4'h8;
	localparam logic [3:0] buffer_data_port_high = 4'h9;
	localparam logic [3:0] LINK_CONFIG_REG_SIX = 4'h6;
	localparam logic [3:0] LINK_CONFIG_REG_SEVEN = 4'h7;
	localparam int SWAP_BIT_POS = 0;
	localparam int BUF_SIZE_BIT_POS = 1;
	localparam int BANK_LO_POS = 2;
	localparam logic [7:0] LINK_RESET_VAL = 8'h00;

	// ------------------------------------------------------------
	// Bank codes and strap modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		HPB_BANK_STATION = 2'h0,
		HPB_BANK_HASH = 2'h1,
		HPB_BANK_PORT = 2'h2,
		HPB_BANK_SPARE = 2'h3
	} hpb_bank_type;

	typedef enum logic [1:0] {
		HPB_MODE_EXP_JUMPERLESS = 2'h0,
		HPB_MODE_EXP_JUMPER = 2'h1,
		HPB_MODE_CARD = 2'h2,
		HPB_MODE_GENERAL = 2'h3
	} hpb_mode_type;

	// ------------------------------------------------------------
	// Buffer sizes and timing
	// ------------------------------------------------------------
	localparam int SMALL_BUF_ADDR_W = 13;
	localparam int LARGE_BUF_ADDR_W = 15;
	localparam int CRYSTAL_MHZ = 20;
	localparam int BIT_RATE_MBPS = 10;
	localparam int BIT_DIV = CRYSTAL_MHZ / BIT_RATE_MBPS;

	// Host request carrier
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [15:0] wdata;
	} hpb_req_type;

endpackage

// ==== hpb_fifo.sv ====
// Small one-direction FIFO used for each data port direction
`timescale 1ns/1ps
`default_nettype none
module hpb_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH_LOG2 = 2
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int DEPTH = 1 << DEPTH_LOG2;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [DEPTH_LOG2:0] wp_q;
	logic [DEPTH_LOG2:0] rp_q;
	logic push;
	logic pop;

	// Full when the indices meet but the wrap bits differ
	assign in_ready = (wp_q[DEPTH_LOG2] == rp_q[DEPTH_LOG2]) ||
		(wp_q[DEPTH_LOG2-1:0] != rp_q[DEPTH_LOG2-1:0]);
	assign out_valid = wp_q != rp_q;
	assign out_data = mem[rp_q[DEPTH_LOG2-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and storage update
	always_ff @(posedge mclk) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) begin
				mem[wp_q[DEPTH_LOG2-1:0]] <= in_data;
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hpb_host_port_properties.sv ====
// Checker for the host port bank block
`timescale 1ns/1ps
`default_nettype none
module hpb_host_port_props (
	input wire logic mclk,
	input wire logic rst,
	input wire logic strap_first,
	input wire logic strap_second,
	input wire logic buffer_data_line_zero,
	input wire logic word_mode,
	input wire logic dma_grant_in,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic host_byte,
	input wire logic [7:0] host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic host_ready,
	input wire logic [1:0] bus_mode,
	input wire logic [14:0] sram_addr,
	input wire logic sram_we_n,
	input wire logic sram_oe_n,
	input wire logic bit_tick
);
	// ------
	// Helpers
	// ------
	logic [2:0] up_q;
	logic small_q;
	logic [1:0] mode_exp;
	// Age since reset and the buffer size seen on host writes
	always_ff @(posedge mclk) begin
		if (rst) begin
			up_q <= 3'h0;
			small_q <= 1'b1;
		end else begin
			if (up_q != 3'h7) up_q <= up_q + 3'h1;
			if (host_wr && host_addr[3:0] == 4'h6) small_q <= ~host_wdata[1];
		end
	end
	// Strap decode, third strap never left high by the bench
	assign mode_exp = strap_first ? {1'b0, ~buffer_data_line_zero} :
		(strap_second ? 2'h2 : 2'h3);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ------
	// Properties
	// ------
	mode_decode_a: assert property (up_q == 3'h3 |-> bus_mode == mode_exp)
		else $error("bus mode differs from straps");
	mode_hold_a: assert property (up_q == 3'h7 |-> $stable(bus_mode))
		else $error("bus mode moved after strap time");
	bit_rate_a: assert property (bit_tick |=> !bit_tick ##1 bit_tick)
		else $error("bit enable not every second cycle");
	link_ready_a: assert property ((host_rd || host_wr) && !dma_grant_in &&
		host_addr[3:0] <= hpb_pkg::LINK_SET_LAST |=> host_ready)
		else $error("link register access not answered");
	ready_cause_a: assert property (host_ready |-> $past(host_rd || host_wr))
		else $error("ready without a request");
	word_only_a: assert property (host_wr && host_byte && word_mode &&
		dma_grant_in |=> !host_ready)
		else $error("byte port access accepted in word mode");
	dma_port_a: assert property (host_wr && !host_byte && word_mode &&
		dma_grant_in |-> ##[2:6] !sram_we_n)
		else $error("granted write never reached buffer");
	small_buf_a: assert property (small_q && !sram_we_n |->
		sram_addr[14:13] == 2'h0)
		else $error("small buffer address overflow");
	sram_excl_a: assert property (!(!sram_we_n && !sram_oe_n))
		else $error("buffer read and write strobes together");
	cover property (host_wr && dma_grant_in);
	cover property (bit_tick);
	cover property (host_ready && word_mode);
endmodule
bind hpb_host_port hpb_host_port_props chk_i (.mclk(mclk), .rst(rst),
	.strap_first(strap_first), .strap_second(strap_second),
	.buffer_data_line_zero(buffer_data_line_zero), .word_mode(word_mode),
	.dma_grant_in(dma_grant_in), .host_rd(host_rd), .host_wr(host_wr),
	.host_byte(host_byte), .host_addr(host_addr), .host_wdata(host_wdata),
	.host_ready(host_ready), .bus_mode(bus_mode), .sram_addr(sram_addr),
	.sram_we_n(sram_we_n), .sram_oe_n(sram_oe_n), .bit_tick(bit_tick));
`default_nettype wire

// ==== hpb_sram_model.sv ====
// Byte-wide buffer SRAM model on the block's memory pins
`timescale 1ns/1ps
`default_nettype none
module hpb_sram_model (
	input wire logic mclk,
	input wire logic [14:0] sram_addr,
	input wire logic [7:0] sram_wdata,
	input wire logic sram_we_n,
	input wire logic sram_oe_n,
	output logic [7:0] sram_rdata
);
	// ------
	// Storage
	// ------
	logic [7:0] mem [0:32767];
	logic [7:0] last_q;
	logic [7:0] wlog [$];
	// Known contents so prefetched reads carry no unknowns
	initial begin
		for (int i = 0; i < 32768; i++) mem[i] = i[7:0];
		last_q = 8'h00;
	end
	// Writes land on the edge where the strobe is seen low
	always @(posedge mclk) begin
		if (!sram_we_n) begin
			mem[sram_addr] = sram_wdata;
			wlog.push_back(sram_wdata);
		end
		if (!sram_oe_n) last_q = mem[sram_addr];
	end
	// Released bus shows the inverse, never a held byte
	assign sram_rdata = sram_oe_n ? ~last_q : mem[sram_addr];
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the host port bank block
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ------
	// Signals
	// ------
	logic mclk, rst, s1, s2, s3, bd0, word_mode, dma, rd, wr, byte_a, rdy;
	logic [7:0] addr, sram_wdata, sram_rdata;
	logic [15:0] wdata, host_rdata, got;
	logic host_ready, bit_tick, we_n, oe_n;
	logic [1:0] bus_mode;
	logic [14:0] sram_addr;
	logic [2:0] tx_pkt_count;
	int fail_count = 0;
	int total_checks = 0;
	typedef struct packed {logic [7:0] wa, wv, ra, ev;} hpb_row_type;
	// Write address and value, read address and expected byte
	hpb_row_type rows [8] = '{32'h0700_0700, 32'h0ba1_0ba1, 32'h0704_0704,
		32'h0bb2_0bb2, 32'h0700_0ba1, 32'h8c66_0c66, 32'h070c_0b00,
		32'h0700_1ba1};
	logic [3:0] straps [4] = '{4'h9, 4'h8, 4'h4, 4'h0};
	hpb_host_port uut (.mclk(mclk), .rst(rst), .strap_first(s1),
		.strap_second(s2), .strap_third(s3), .buffer_data_line_zero(bd0),
		.word_mode(word_mode), .dma_grant_in(dma), .host_rd(rd),
		.host_wr(wr), .host_byte(byte_a), .host_addr(addr),
		.host_wdata(wdata), .host_rdata(host_rdata),
		.host_ready(host_ready), .bus_mode(bus_mode),
		.sram_addr(sram_addr), .sram_wdata(sram_wdata),
		.sram_rdata(sram_rdata), .sram_we_n(we_n), .sram_oe_n(oe_n),
		.bit_tick(bit_tick), .tx_pkt_count(tx_pkt_count));
	hpb_sram_model mdl (.mclk(mclk), .sram_addr(sram_addr),
		.sram_wdata(sram_wdata), .sram_we_n(we_n), .sram_oe_n(oe_n),
		.sram_rdata(sram_rdata));
	// ------
	// Tasks
	// ------
	task automatic chk(input string what, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One request cycle, answer taken one cycle later
	task automatic acc(input logic r, w, b, input logic [7:0] a,
		input logic [15:0] d);
		@(negedge mclk);
		rd = r;
		wr = w;
		byte_a = b;
		addr = a;
		wdata = d;
		@(negedge mclk);
		rd = 0;
		wr = 0;
		rdy = host_ready;
		got = host_rdata;
	endtask
	task automatic do_reset(input logic [3:0] st);
		@(negedge mclk);
		{s1, s2, s3, bd0} = st;
		rst = 1;
		repeat (5) @(negedge mclk);
		rst = 0;
	endtask
	// Set bank and swap, write the port, compare bytes in buffer order
	task automatic port_case(input logic [7:0] cfg, input logic wm, b, g,
		input logic [15:0] d, input int n, input logic [15:0] e);
		word_mode = wm;
		acc(0, 1, 1, 8'h07, {8'h00, cfg});
		dma = g;
		mdl.wlog.delete();
		acc(0, 1, b, 8'h08, d);
		repeat (8) @(negedge mclk);
		dma = 0;
		chk("port ready", {15'h0, rdy}, {15'h0, n != 0});
		chk("byte count", 16'(mdl.wlog.size()), 16'(n));
		if (n > 0) chk("first byte", {8'h00, mdl.wlog[0]}, {8'h00, e[7:0]});
		if (n > 1) chk("second byte", {8'h00, mdl.wlog[1]}, {8'h00, e[15:8]});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Free running clock, 20 ns period
	initial begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	// Hang guard, far beyond the roughly 150 cycles needed
	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		{rst, s1, s2, s3, bd0, word_mode, dma, rd, wr, byte_a} = 10'h200;
		addr = 8'h00;
		wdata = 16'h0000;
		do_reset(4'h0);
		for (int i = 0; i < 8; i++) begin
			acc(0, 1, 1, rows[i].wa, {8'h00, rows[i].wv});
			acc(1, 0, 1, rows[i].ra, 16'h0000);
			chk("reg read", {8'h00, got[7:0]}, {8'h00, rows[i].ev});
		end
		for (int i = 0; i < 4; i++) begin
			do_reset(straps[i]);
			repeat (3) @(negedge mclk);
			chk("bus mode", {14'h0, bus_mode}, 16'(i));
			chk("strobes idle", {14'h0, we_n, oe_n}, 16'h0003);
		end
		port_case(8'h08, 1, 0, 0, 16'h1234, 2, 16'h1234);
		port_case(8'h09, 1, 0, 0, 16'habcd, 2, 16'hcdab);
		port_case(8'h09, 0, 1, 0, 16'h0056, 1, 16'h0056);
		port_case(8'h08, 1, 1, 1, 16'h0077, 0, 16'h0000);
		port_case(8'h01, 1, 0, 1, 16'h2468, 2, 16'h6824);
		// Frame load with the port bank held, then a two packet start
		acc(0, 1, 1, 8'h07, 16'h0008);
		mdl.wlog.delete();
		acc(0, 1, 0, 8'h08, 16'h000e);
		acc(0, 1, 0, 8'h08, 16'h2211);
		acc(0, 1, 1, 8'h0a, 16'h0082);
		chk("packets queued", {13'h0, tx_pkt_count}, 16'h0002);
		repeat (10) @(negedge mclk);
		chk("packets sent", {13'h0, tx_pkt_count}, 16'h0000);
		chk("length first", {8'h00, mdl.wlog[0]}, 16'h000e);
		acc(1, 0, 0, 8'h08, 16'h0000);
		chk("port read ready", {15'h0, rdy}, 16'h0001);
		tally_and_finish();
	end
endmodule
`default_nettype wire
